// ===== tws_bus_master.sv
// behavioural two-wire bus master transmitter
module tws_bus_master (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_d,
    output logic      sda_d
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {scl_d, sda_d} = 2'b11;
    // release clock, then wait out stretching
    task automatic rise();
        scl_d = 1'b1;
        for (int n = 0; n < 9000 && scl !== 1'b1; n++) #10;
        #20;
    endtask
    // start when s is high, else stop
    task automatic cond(input logic s);
        sda_d = s;
        #20;
        rise();
        sda_d = !s;
        #40;
        scl_d = !s;
        #20;
    endtask
    // msb first, ninth clock samples acknowledge
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--)
        begin
            sda_d = (i > 0) ? b[i-1] : 1'b1;
            #20;
            rise();
            ack = sda;
            #20;
            scl_d = 1'b0;
            #20;
        end
        #40;
    endtask
endmodule

// ===== tws_pkg.sv
// package: constants, types and register map of the two-wire slave receiver
//----------------------------------------------------------------------------
// Summary of operation
// R1 - respond when address matches upper seven bits
// R2 - general call only when enable bit set
// R3 - software enables interface and acknowledge first
// R4 - direction bit zero selects slave receive
// R5 - own address write sets flag with status
// R6 - lost arbitration reports 0x68 or 0x78
// R7 - acknowledge cleared gives not-acknowledge next byte
// R8 - acknowledge disabled ignores own address
// R9 - deep sleep still recognises address, wakes
// R10 - hold clock low until flag cleared; the code leaves it released after stop or restart (status 0xA0)
// R11 - data register may miss byte after wake
// R12 - own address acknowledged reports 0x60
// R13 - general call acknowledged reports 0x70
// R14 - own data reports 0x80 or 0x88
// R15 - general call data reports 0x90 or 0x98
// R16 - flag clear receives next byte per acknowledge
// R17 - after not-acknowledge, clear makes not-addressed
// R18 - start request then sends start when free
// R19 - status low bits read as zero
// R20 - stop or restart while addressed reports 0xA0
// R21 - stretch clock while flag set; the code does not stretch after stop or restart (status 0xA0)
//----------------------------------------------------------------------------
package tws_pkg;

    //------------------------------------------------------------------------
    // register map
    //------------------------------------------------------------------------
    localparam int          REG_AW         = 3;
    localparam logic [2:0]  OFS_CONTROL    = 3'h0;
    localparam logic [2:0]  OFS_STATUS     = 3'h1;
    localparam logic [2:0]  OFS_DATA       = 3'h2;
    localparam logic [2:0]  OFS_OWN_ADDR   = 3'h3;
    localparam logic [7:0]  READ_UNMAPPED  = 8'h00;
    localparam logic [7:0]  OWN_ADDR_RESET = 8'h00;
    localparam logic [7:0]  DATA_RESET     = 8'hFF;

    //------------------------------------------------------------------------
    // status codes, low three bits always zero
    //------------------------------------------------------------------------
    localparam logic [7:0]  ST_IDLE        = 8'hF8;
    localparam logic [7:0]  ST_OWN_ACK     = 8'h60;
    localparam logic [7:0]  ST_ARB_OWN     = 8'h68;
    localparam logic [7:0]  ST_GC_ACK      = 8'h70;
    localparam logic [7:0]  ST_ARB_GC      = 8'h78;
    localparam logic [7:0]  ST_OWN_DATA_A  = 8'h80;
    localparam logic [7:0]  ST_OWN_DATA_N  = 8'h88;
    localparam logic [7:0]  ST_GC_DATA_A   = 8'h90;
    localparam logic [7:0]  ST_GC_DATA_N   = 8'h98;
    localparam logic [7:0]  ST_STOP_RESTART = 8'hA0;
    localparam logic [2:0]  STATUS_LOW_MASK = 3'h0;

    localparam logic [6:0]  BROADCAST_ADDR = 7'h00;
    localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
    localparam logic [3:0]  CNT_ZERO       = 4'h0;
    localparam logic [3:0]  CNT_ONE        = 4'h1;

    //------------------------------------------------------------------------
    // types
    //------------------------------------------------------------------------
    typedef struct packed {
        logic event_flag;
        logic ack_enable;
        logic start_request;
        logic stop_request;
        logic write_collision_flag;
        logic interface_enable;
        logic reserved;
        logic event_irq_enable;
    } tws_ctrl_t;

    localparam tws_ctrl_t CTRL_RESET = '0;

    typedef struct packed {
        logic [REG_AW-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } tws_req_t;

    typedef struct packed {
        logic oe;
        logic o;
    } tws_pin_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_AACK,
        S_DATA,
        S_DACK,
        S_HOLD,
        S_IGNORE
    } tws_state_t;

endpackage

// ===== tws_slave_rx.sv
// module: two-wire slave receiver with register port
module tws_slave_rx (
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire logic                          ce,
    input  wire logic [tws_pkg::REG_AW-1:0]    reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [7:0]                    reg_rdata,
    input  wire logic                          scl_i,
    output logic                               scl_o,
    output logic                               scl_oe,
    input  wire logic                          sda_i,
    output logic                               sda_o,
    output logic                               sda_oe,
    input  wire logic                          arb_lost,
    input  wire logic                          deep_sleep,
    output logic                               wake_req,
    output logic                               start_tx
);

    //------------------------------------------------------------------------
    // state
    //------------------------------------------------------------------------
    typedef struct packed {
        tws_pkg::tws_state_t st;
        logic [3:0]          bit_cnt;
        logic [7:0]          shift;
        tws_pkg::tws_ctrl_t  ctrl;
        logic [7:0]          own;
        logic [7:0]          status;
        logic [7:0]          data;
        logic                gc;
        logic                arb;
        logic                nack_hold;
        logic                quiet;
        logic                ack_bit;
        logic                sda_drv;
        logic                scl_q;
        logic                sda_q;
        logic                busy;
        logic                start_pend;
        logic                start_pulse;
        logic [7:0]          rdata;
    } tws_rx_st_t;

    localparam tws_rx_st_t RX_RESET = '{
        st:          tws_pkg::S_IDLE,
        bit_cnt:     tws_pkg::CNT_ZERO,
        shift:       tws_pkg::DATA_RESET,
        ctrl:        tws_pkg::CTRL_RESET,
        own:         tws_pkg::OWN_ADDR_RESET,
        status:      tws_pkg::ST_IDLE,
        data:        tws_pkg::DATA_RESET,
        gc:          1'b0,
        arb:         1'b0,
        nack_hold:   1'b0,
        quiet:       1'b0,
        ack_bit:     1'b0,
        sda_drv:     1'b0,
        scl_q:       1'b1,
        sda_q:       1'b1,
        busy:        1'b0,
        start_pend:  1'b0,
        start_pulse: 1'b0,
        rdata:       tws_pkg::READ_UNMAPPED
    };

    tws_rx_st_t r_reg;
    tws_rx_st_t r_next;
    logic [1:0] pins_sync;
    tws_pkg::tws_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    //------------------------------------------------------------------------
    // pin synchroniser
    //------------------------------------------------------------------------
    tws_sync #(
        .W        (2)
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .async_in ({scl_i, sda_i}),
        .sync_out (pins_sync)
    );
    // slave receive status for a finished address or data phase
    function automatic logic [7:0] rx_code(input logic is_addr, input logic gc,
                                           input logic arb, input logic ack);
        if (is_addr)
            return gc ? (arb ? tws_pkg::ST_ARB_GC : tws_pkg::ST_GC_ACK)
                      : (arb ? tws_pkg::ST_ARB_OWN : tws_pkg::ST_OWN_ACK);
        if (gc)
            return ack ? tws_pkg::ST_GC_DATA_A : tws_pkg::ST_GC_DATA_N;
        return ack ? tws_pkg::ST_OWN_DATA_A : tws_pkg::ST_OWN_DATA_N;
    endfunction

    //------------------------------------------------------------------------
    // next state
    //------------------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic own_m;
    logic gc_m;
    logic set_flag;

    always_comb
    begin
        scl_s    = pins_sync[1];
        sda_s    = pins_sync[0];
        scl_rise = scl_s & ~r_reg.scl_q;
        scl_fall = ~scl_s & r_reg.scl_q;
        start_c  = scl_s & r_reg.scl_q & r_reg.sda_q & ~sda_s;
        stop_c   = scl_s & r_reg.scl_q & ~r_reg.sda_q & sda_s;
        own_m    = r_reg.shift[7:1] == r_reg.own[7:1];                      // see R1
        gc_m     = (r_reg.shift[7:1] == tws_pkg::BROADCAST_ADDR) && r_reg.own[0]; // see R2
        set_flag = 1'b0;
        r_next             = r_reg;
        r_next.scl_q       = scl_s;
        r_next.sda_q       = sda_s;
        r_next.start_pulse = 1'b0;
        r_next.rdata       = tws_pkg::READ_UNMAPPED;
        if (start_c)
            r_next.busy = 1'b1;
        else if (stop_c)
            r_next.busy = 1'b0;
        if (arb_lost)
            r_next.arb = 1'b1;
        // register reads
        if (req.rd)
        begin
            unique case (req.addr)
                tws_pkg::OFS_CONTROL:  r_next.rdata = r_reg.ctrl;
                tws_pkg::OFS_STATUS:   r_next.rdata = {r_reg.status[7:3],
                                                       tws_pkg::STATUS_LOW_MASK}; // see R19
                tws_pkg::OFS_DATA:     r_next.rdata = r_reg.data;
                tws_pkg::OFS_OWN_ADDR: r_next.rdata = r_reg.own;
                default:               r_next.rdata = tws_pkg::READ_UNMAPPED;
            endcase
        end
        // register writes; flag is write-one-to-clear
        if (req.wr)
        begin
            unique case (req.addr)
                tws_pkg::OFS_CONTROL:
                begin
                    r_next.ctrl = reg_wdata;
                    r_next.ctrl.event_flag = r_reg.ctrl.event_flag & ~reg_wdata[7];
                    r_next.ctrl.write_collision_flag = r_reg.ctrl.write_collision_flag;
                    r_next.ctrl.reserved = 1'b0;
                end
                tws_pkg::OFS_DATA:
                begin
                    if (r_reg.ctrl.event_flag)
                    begin
                        r_next.data = reg_wdata;
                        r_next.ctrl.write_collision_flag = 1'b0;
                    end
                    else
                        r_next.ctrl.write_collision_flag = 1'b1;
                end
                tws_pkg::OFS_OWN_ADDR: r_next.own = reg_wdata;
                default:               ;
            endcase
        end
        // bus sequencer
        unique case (r_reg.st)
            tws_pkg::S_IDLE:
            begin
                if (start_c)
                begin
                    r_next.st      = tws_pkg::S_ADDR;
                    r_next.bit_cnt = tws_pkg::CNT_ZERO;
                end
                else if (r_reg.start_pend && !r_reg.busy)
                begin
                    r_next.start_pulse = 1'b1;                    // see R18
                    r_next.start_pend  = 1'b0;
                end
            end
            tws_pkg::S_ADDR:
            begin
                if (stop_c)
                    r_next.st = tws_pkg::S_IDLE;
                else if (start_c)
                    r_next.bit_cnt = tws_pkg::CNT_ZERO;
                else if (scl_rise)
                begin
                    r_next.shift   = {r_reg.shift[6:0], sda_s};
                    r_next.bit_cnt = r_reg.bit_cnt + tws_pkg::CNT_ONE;
                end
                else if (scl_fall && r_reg.bit_cnt == tws_pkg::BITS_PER_BYTE)
                begin
                    // write direction only; read direction is not served here
                    if (r_reg.ctrl.ack_enable && !r_reg.shift[0] && (own_m || gc_m)) // see R4, R8
                    begin
                        r_next.st      = tws_pkg::S_AACK;
                        r_next.sda_drv = 1'b1;
                        r_next.gc      = ~own_m;
                    end
                    else
                        r_next.st = tws_pkg::S_IGNORE;
                end
            end
            tws_pkg::S_AACK:
            begin
                if (scl_fall)
                begin
                    r_next.sda_drv   = 1'b0;
                    set_flag         = 1'b1;                      // see R5, R9
                    r_next.status    = rx_code(1'b1, r_reg.gc, r_reg.arb, 1'b1); // see R6, R12, R13
                    r_next.arb       = 1'b0;
                    r_next.st        = tws_pkg::S_HOLD;
                    r_next.nack_hold = 1'b0;
                    r_next.quiet     = 1'b0;
                end
            end
            tws_pkg::S_DATA, tws_pkg::S_DACK:
            begin
                if (start_c || stop_c)
                begin
                    r_next.sda_drv   = 1'b0;
                    set_flag         = 1'b1;
                    r_next.status    = tws_pkg::ST_STOP_RESTART;  // see R20
                    r_next.st        = tws_pkg::S_HOLD;
                    r_next.nack_hold = 1'b1;
                    r_next.quiet     = 1'b1;
                end
                else if (r_reg.st == tws_pkg::S_DATA && scl_rise)
                begin
                    r_next.shift   = {r_reg.shift[6:0], sda_s};
                    r_next.bit_cnt = r_reg.bit_cnt + tws_pkg::CNT_ONE;
                end
                else if (r_reg.st == tws_pkg::S_DATA && scl_fall
                         && r_reg.bit_cnt == tws_pkg::BITS_PER_BYTE)
                begin
                    r_next.ack_bit = r_reg.ctrl.ack_enable;       // see R7, R16
                    r_next.sda_drv = r_reg.ctrl.ack_enable;
                    r_next.st      = tws_pkg::S_DACK;
                end
                else if (r_reg.st == tws_pkg::S_DACK && scl_fall)
                begin
                    r_next.sda_drv = 1'b0;
                    if (!deep_sleep)
                        r_next.data = r_reg.shift;                // see R11
                    set_flag         = 1'b1;
                    r_next.status    = rx_code(1'b0, r_reg.gc, 1'b0, r_reg.ack_bit); // see R14, R15
                    r_next.st        = tws_pkg::S_HOLD;
                    r_next.nack_hold = ~r_reg.ack_bit;
                    r_next.quiet     = 1'b0;
                end
            end
            tws_pkg::S_HOLD:
            begin
                // leave once software has cleared the flag
                if (!r_reg.ctrl.event_flag)
                begin
                    r_next.bit_cnt = tws_pkg::CNT_ZERO;
                    if (r_reg.nack_hold)
                    begin
                        r_next.st         = tws_pkg::S_IDLE;      // see R17
                        r_next.start_pend = r_reg.ctrl.start_request; // see R18
                    end
                    else
                        r_next.st = tws_pkg::S_DATA;              // see R16
                end
            end
            tws_pkg::S_IGNORE:
            begin
                if (stop_c)
                    r_next.st = tws_pkg::S_IDLE;
                else if (start_c)
                begin
                    r_next.st      = tws_pkg::S_ADDR;
                    r_next.bit_cnt = tws_pkg::CNT_ZERO;
                end
            end
            default:
                r_next.st = tws_pkg::S_IDLE;
        endcase
        if (!r_reg.ctrl.interface_enable)
        begin
            r_next.st      = tws_pkg::S_IDLE;
            r_next.sda_drv = 1'b0;
        end
        // hardware set wins over a software clear in the same cycle
        if (set_flag)
            r_next.ctrl.event_flag = 1'b1;
    end

    //------------------------------------------------------------------------
    // registers
    //------------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            r_reg <= RX_RESET;
        else if (ce)
            r_reg <= r_next;
    end

    //------------------------------------------------------------------------
    // outputs
    //------------------------------------------------------------------------
    assign reg_rdata = r_reg.rdata;
    assign scl_o     = 1'b0;
    assign sda_o     = 1'b0;
    assign scl_oe    = (r_reg.st == tws_pkg::S_HOLD) && !r_reg.quiet; // see R10, R21
    assign sda_oe    = r_reg.sda_drv;
    assign wake_req  = deep_sleep && r_reg.ctrl.event_flag;          // see R9
    assign start_tx  = r_reg.start_pulse;

    //------------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n || !ce);
    property p_stretch;
        (r_reg.st == tws_pkg::S_HOLD && r_reg.ctrl.event_flag
            && r_reg.status != tws_pkg::ST_STOP_RESTART) |-> scl_oe;
    endproperty
    a_stretch: assert property (p_stretch) else $error("clock not held while flag set"); // see R21
    property p_release;
        $fell(r_reg.ctrl.event_flag) |=> !scl_oe;
    endproperty
    a_release: assert property (p_release) else $error("clock held after flag clear"); // see R10
    property p_gc_enable;
        $rose(r_reg.ctrl.event_flag) && r_reg.status == tws_pkg::ST_GC_ACK |-> r_reg.own[0];
    endproperty
    a_gc_enable: assert property (p_gc_enable) else $error("general call taken while off"); // see R2
    property p_own_match;
        $rose(r_reg.ctrl.event_flag) && r_reg.status == tws_pkg::ST_OWN_ACK
            |-> r_reg.shift[7:1] == r_reg.own[7:1] && !r_reg.shift[0];
    endproperty
    a_own_match: assert property (p_own_match) else $error("own status without match"); // see R1
    property p_addr_ack;
        r_reg.st == tws_pkg::S_ADDR ##1 r_reg.st == tws_pkg::S_AACK
            |-> $past(r_reg.ctrl.ack_enable) && sda_oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address acked while disabled"); // see R8
    property p_nack;
        r_reg.st == tws_pkg::S_DACK && !r_reg.ack_bit |-> !sda_oe;
    endproperty
    a_nack: assert property (p_nack) else $error("data acked while disabled"); // see R7
    property p_status_low;
        r_reg.status[2:0] == tws_pkg::STATUS_LOW_MASK;
    endproperty
    a_status_low: assert property (p_status_low) else $error("status low bits set"); // see R19
    property p_stop_addr;
        r_reg.st == tws_pkg::S_DATA && r_reg.ctrl.interface_enable && (start_c || stop_c)
            |=> r_reg.status == tws_pkg::ST_STOP_RESTART && r_reg.ctrl.event_flag;
    endproperty
    a_stop_addr: assert property (p_stop_addr) else $error("stop while addressed missed"); // see R20
    property p_data_code;
        r_reg.st == tws_pkg::S_DACK && scl_fall && r_reg.ctrl.interface_enable
            && !start_c && !stop_c |=> r_reg.status == (r_reg.gc
            ? ($past(r_reg.ack_bit) ? tws_pkg::ST_GC_DATA_A : tws_pkg::ST_GC_DATA_N)
            : ($past(r_reg.ack_bit) ? tws_pkg::ST_OWN_DATA_A : tws_pkg::ST_OWN_DATA_N));
    endproperty
    a_data_code: assert property (p_data_code) else $error("wrong data status"); // see R14, R15

endmodule

// ===== tws_sync.sv
// module: two flip-flop synchroniser for the bus pins
module tws_sync #(
    parameter int W = 2
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } tws_sync_st_t;

    tws_sync_st_t sync_reg;
    tws_sync_st_t sync_next;

    always_comb
    begin
        sync_next        = sync_reg;
        sync_next.meta   = async_in;
        sync_next.stable = sync_reg.meta;
    end

    // bus idles high, so both stages reset high
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            sync_reg <= '1;
        else if (ce)
            sync_reg <= sync_next;
    end

    assign sync_out = sync_reg.stable;

endmodule

// ===== tws_tb_top.sv
// self-checking bench for the two-wire slave receiver
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       arb_lost = 1'b0;
    logic       deep_sleep = 1'b0;
    logic       tx_seen = 1'b0;
    logic       scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, wake_req, start_tx, ack;
    int         fails = 0;
    int         total_checks = 0;
    wire        scl_w = m_scl & ~scl_oe;
    wire        sda_w = m_sda & ~sda_oe;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (start_tx === 1'b1) tx_seen <= 1'b1;
    tws_slave_rx DUT (
        .core_clk, .rst_n, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .scl_i(scl_w), .scl_o, .scl_oe, .sda_i(sda_w), .sda_o, .sda_oe,
        .arb_lost, .deep_sleep, .wake_req, .start_tx
    );
    tws_bus_master m (.scl(scl_w), .sda(sda_w), .scl_d(m_scl), .sda_d(m_sda));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask
    // register write, or read and compare
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge core_clk);
        {reg_wr, reg_rd} <= 2'b00;
        #1;
        if (!w) chk(reg_rdata, d);
    endtask
    // optional start, one byte, acknowledge compare and status compare unless st is zero
    task automatic xb(input logic s, input logic [7:0] b, input logic e, input logic [7:0] st);
        if (s) m.cond(1'b1);
        m.send(b, ack);
        chk({7'h0, ack}, {7'h0, e});
        if (st != 8'h00) acc(1'b0, 3'h1, st);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #400_000;
        fails++;
        end_sim();
    end
    initial
    begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        acc(1'b0, 3'h1, 8'hF8);
        acc(1'b0, 3'h2, 8'hFF);
        acc(1'b0, 3'h6, 8'h00);
        acc(1'b1, 3'h3, 8'hA9);
        acc(1'b1, 3'h0, 8'h44);
        xb(1'b1, 8'hA8, 1'b0, 8'h60);
        acc(1'b0, 3'h0, 8'hC4);
        chk({7'h0, scl_oe}, 8'h01);
        acc(1'b1, 3'h0, 8'hC4);
        xb(1'b0, 8'h5A, 1'b0, 8'h80);
        acc(1'b0, 3'h2, 8'h5A);
        acc(1'b1, 3'h0, 8'h84);
        xb(1'b0, 8'h33, 1'b1, 8'h88);
        acc(1'b1, 3'h0, 8'hC4);
        xb(1'b0, 8'hFF, 1'b1, 8'h00);
        $display("test own address done");
        xb(1'b1, 8'h00, 1'b0, 8'h70);
        acc(1'b1, 3'h0, 8'hC4);
        xb(1'b0, 8'h11, 1'b0, 8'h90);
        acc(1'b1, 3'h0, 8'h84);
        xb(1'b0, 8'h22, 1'b1, 8'h98);
        acc(1'b1, 3'h0, 8'hC4);
        $display("test general call done");
        acc(1'b1, 3'h3, 8'hA8);
        xb(1'b1, 8'h00, 1'b1, 8'h00);
        xb(1'b1, 8'hAA, 1'b1, 8'h00);
        xb(1'b1, 8'hA9, 1'b1, 8'h00);
        acc(1'b1, 3'h0, 8'h04);
        xb(1'b1, 8'hA8, 1'b1, 8'h00);
        acc(1'b1, 3'h0, 8'h44);
        xb(1'b1, 8'hA8, 1'b0, 8'h60);
        acc(1'b1, 3'h0, 8'hC4);
        m.cond(1'b0);
        acc(1'b0, 3'h1, 8'hA0);
        chk({7'h0, tx_seen}, 8'h00);
        acc(1'b1, 3'h0, 8'hE4);
        #200;
        chk({7'h0, tx_seen}, 8'h01);
        acc(1'b1, 3'h0, 8'h44);
        $display("test refusal done");
        acc(1'b1, 3'h3, 8'hA9);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge core_clk) arb_lost <= 1'b1;
            @(posedge core_clk) arb_lost <= 1'b0;
            xb(1'b1, i ? 8'h00 : 8'hA8, 1'b0, i ? 8'h78 : 8'h68);
            acc(1'b1, 3'h0, 8'hC4);
            m.cond(1'b0);
            acc(1'b1, 3'h0, 8'hC4);
        end
        @(posedge core_clk) deep_sleep <= 1'b1;
        xb(1'b1, 8'hA8, 1'b0, 8'h60);
        chk({7'h0, wake_req}, 8'h01);
        chk({7'h0, scl_oe}, 8'h01);
        @(posedge core_clk) deep_sleep <= 1'b0;
        acc(1'b1, 3'h0, 8'hC4);
        #20;
        chk({7'h0, scl_oe}, 8'h00);
        chk({6'h0, scl_o, sda_o}, 8'h00);
        xb(1'b0, 8'h77, 1'b0, 8'h80);
        acc(1'b1, 3'h0, 8'hC4);
        m.cond(1'b0);
        acc(1'b1, 3'h0, 8'hC4);
        $display("test arbitration and sleep done");
        end_sim();
    end
endmodule
